//--- rtl/conic_generator.sv
// Conic generator end: word capture, phase timing, unblank, video, diagnostics
//
// Behaviour
// - Two words per conic, major then minor
// - Y at low field, X at high
// - One's complement, both zeros accepted
// - Minor word uses the same fields
// - Ten-bit components, step 1/512 diameter
// - Twenty data lines, one strobe per word
// - Sender spaces strobe leading edges 8 us
// - Sender waits for reset after second strobe
// - Reset line tells sender to continue
// - Six-line diagnostic instruction input
// - Return thirteen diagnostic bits when asked
// - Logic paced by 1.536 MHz timing clock
// - Four brightness bands from major size
// - Unblank pulse 83.3 to 90 us
// - Deflection samples repeat at 12 kHz
// - Panel synthesizes words in test mode
// - Each strobe loads its own register
// - Four 12 kHz phases step registers out
// - Brightness from two top magnitude bits
// - Whole conic within 550 us
`timescale 1ns/100ps
module conic_generator
	import conic_pkg::*;
#(
	parameter int unsigned unblank_cyc = UNBLANK_MIN_CYC,
	parameter int unsigned gen_max_cyc = GEN_MAX_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Link to the display logic
	conic_link_if.generator link,
	// Master timing unit
	input wire logic timing_clk,
	input wire logic [DIAG_INSTR_W-1:0] diag_instr,
	output logic [DIAG_DATA_W-1:0] diag_data,
	output logic diag_sync,
	// Display outputs
	output logic unblank,
	output logic [1:0] video_level,
	output logic [3:0] phase,
	output logic [COMP_W-1:0] ax_sample,
	output logic [COMP_W-1:0] ay_sample,
	output logic [COMP_W-1:0] bx_sample,
	output logic [COMP_W-1:0] by_sample
);

	// Top two magnitude bits of a one's complement value; both zeros give zero
	function automatic logic [1:0] band(input logic [COMP_W-1:0] v);
		band = v[COMP_W-1] ? ~v[COMP_W-2 -: 2] : v[COMP_W-2 -: 2];
	endfunction

	// Drive a component or its one's complement negative
	function automatic logic [COMP_W-1:0] signed_step(input logic [COMP_W-1:0] v,
		input logic positive);
		signed_step = positive ? v : ~v;
	endfunction

	gen_state_type state_r;
	logic [WORD_W-1:0] major_r;
	logic [WORD_W-1:0] minor_r;
	logic major_q;
	logic minor_q;
	logic major_rise;
	logic minor_rise;
	logic tclk_s1;
	logic tclk_s2;
	logic tclk_s3;
	logic tick;
	logic [PHASE_CNT_W-1:0] ph_cnt_r;
	logic [3:0] phase_nxt;
	logic wrap;
	logic [GEN_CNT_W-1:0] gen_cnt_r;
	logic [GEN_CNT_W-1:0] blank_cnt_r;
	logic [DIAG_INSTR_W-1:0] instr_s1;
	logic [DIAG_INSTR_W-1:0] instr_s2;
	logic [DIAG_INSTR_W-1:0] instr_q;
	logic [COMP_W-1:0] ax;
	logic [COMP_W-1:0] ay;
	logic [COMP_W-1:0] bx;
	logic [COMP_W-1:0] by;
	logic [1:0] level_x;
	logic [1:0] level_y;
	logic draw_on;

	assign ay = major_r[FIELD_Y_LSB +: COMP_W];
	assign ax = major_r[FIELD_X_LSB +: COMP_W];
	assign by = minor_r[FIELD_Y_LSB +: COMP_W];
	assign bx = minor_r[FIELD_X_LSB +: COMP_W];

	assign major_rise = link.strobe_major & ~major_q;
	assign minor_rise = link.strobe_minor & ~minor_q;

	////////////////////////////////////////////////////////////////////////
	// Timing clock and instruction come from another unit: two flops first
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tclk_s1 <= 1'b0;
			tclk_s2 <= 1'b0;
			tclk_s3 <= 1'b0;
			instr_s1 <= '0;
			instr_s2 <= '0;
		end else begin
			tclk_s1 <= timing_clk;
			tclk_s2 <= tclk_s1;
			tclk_s3 <= tclk_s2;
			instr_s1 <= diag_instr;
			instr_s2 <= instr_s1;
		end
	end

	assign tick = tclk_s2 & ~tclk_s3;

	////////////////////////////////////////////////////////////////////////
	// Divide the timing clock by 128 into four quarter-shifted square waves
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ph_cnt_r <= '0;
		end else if (tick) begin
			ph_cnt_r <= ph_cnt_r + 1'b1;
		end
	end

	assign wrap = tick && ph_cnt_r == PHASE_LAST;

	for (genvar k = 0; k < 4; k++) begin : g_phase
		logic [PHASE_CNT_W-1:0] shifted;
		assign shifted = ph_cnt_r + PHASE_CNT_W'(PHASE_STEP * k);
		assign phase_nxt[k] = ~shifted[PHASE_CNT_W-1];
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			phase <= 4'h0;
		end else begin
			phase <= phase_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Conic sequence
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= GEN_ARM_MAJOR;
		end else begin
			unique case (state_r)
				GEN_ARM_MAJOR: begin
					if (major_rise) begin
						state_r <= GEN_ARM_MINOR;
					end
				end
				GEN_ARM_MINOR: begin
					if (minor_rise) begin
						state_r <= GEN_ALIGN;
					end
				end
				GEN_ALIGN: begin
					if (gen_cnt_r == GEN_CNT_W'(gen_max_cyc - 1)) begin
						state_r <= GEN_RELEASE;
					end else if (wrap) begin
						state_r <= GEN_DRAW;
					end
				end
				GEN_DRAW: begin
					if (blank_cnt_r == GEN_CNT_W'(unblank_cyc - 1) ||
						gen_cnt_r == GEN_CNT_W'(gen_max_cyc - 1)) begin
						state_r <= GEN_RELEASE;
					end
				end
				GEN_RELEASE: state_r <= GEN_ARM_MAJOR;
				default: state_r <= GEN_ARM_MAJOR;
			endcase
		end
	end

	assign link.ready_reset = state_r == GEN_RELEASE;

	////////////////////////////////////////////////////////////////////////
	// Strobe edges and word registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			major_q <= 1'b0;
			minor_q <= 1'b0;
			major_r <= WORD_RESET;
			minor_r <= WORD_RESET;
		end else begin
			major_q <= link.strobe_major;
			minor_q <= link.strobe_minor;
			if (state_r == GEN_ARM_MAJOR && major_rise) begin
				major_r <= link.data;
			end
			if (state_r == GEN_ARM_MINOR && minor_rise) begin
				minor_r <= link.data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Time since second strobe, and unblank length
	// One full deflection period at the least width; samples share it with unblank
	assign draw_on = (state_r == GEN_ALIGN && wrap) ||
		(state_r == GEN_DRAW && blank_cnt_r != GEN_CNT_W'(unblank_cyc - 1) &&
		gen_cnt_r != GEN_CNT_W'(gen_max_cyc - 1));
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			gen_cnt_r <= '0;
			blank_cnt_r <= '0;
			unblank <= 1'b0;
		end else begin
			gen_cnt_r <= (state_r == GEN_ALIGN || state_r == GEN_DRAW) ?
				gen_cnt_r + 1'b1 : '0;
			blank_cnt_r <= (state_r == GEN_DRAW) ? blank_cnt_r + 1'b1 : '0;
			unblank <= draw_on;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Deflection samples: a on the sine phase, b on the cosine phase
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ax_sample <= COMP_ZERO;
			ay_sample <= COMP_ZERO;
			bx_sample <= COMP_ZERO;
			by_sample <= COMP_ZERO;
		end else if (draw_on) begin
			ax_sample <= signed_step(ax, phase_nxt[0]);
			ay_sample <= signed_step(ay, phase_nxt[0]);
			bx_sample <= signed_step(bx, phase_nxt[1]);
			by_sample <= signed_step(by, phase_nxt[1]);
		end else begin
			ax_sample <= COMP_ZERO;
			ay_sample <= COMP_ZERO;
			bx_sample <= COMP_ZERO;
			by_sample <= COMP_ZERO;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Brightness: quarter band of the larger major component
	assign level_x = band(ax);
	assign level_y = band(ay);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			video_level <= 2'h0;
		end else begin
			video_level <= (level_x > level_y) ? level_x : level_y;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Diagnostics: answer on each change of a nonzero instruction
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			instr_q <= '0;
			diag_sync <= 1'b0;
			diag_data <= '0;
		end else begin
			instr_q <= instr_s2;
			diag_sync <= 1'b0;
			if (instr_s2 != instr_q && instr_s2 != '0) begin
				diag_sync <= 1'b1;
				unique case (instr_s2[2:0])
					DIAG_SEL_STATUS: diag_data <= {state_r, video_level, phase,
						unblank, link.ready_reset};
					DIAG_SEL_AX: diag_data <= {3'h0, ax};
					DIAG_SEL_AY: diag_data <= {3'h0, ay};
					DIAG_SEL_BX: diag_data <= {3'h0, bx};
					DIAG_SEL_BY: diag_data <= {3'h0, by};
					default: diag_data <= '0;
				endcase
			end
		end
	end

endmodule

//--- rtl/conic_link_if.sv
// Link between the display logic sender and the conic generator
`timescale 1ns/100ps
interface conic_link_if;
	import conic_pkg::*;

	logic [WORD_W-1:0] data;
	logic strobe_major;
	logic strobe_minor;
	logic ready_reset;

	modport generator (
		input data,
		input strobe_major,
		input strobe_minor,
		output ready_reset
	);

	modport sender (
		output data,
		output strobe_major,
		output strobe_minor,
		input ready_reset
	);
endinterface

//--- rtl/conic_pkg.sv
// Shared constants and types for the conic word link and its two ends
package conic_pkg;

	// Word layout on the 20 data lines: Y field low, X field high
	localparam int WORD_W = 20;
	localparam int COMP_W = 10;
	localparam int FIELD_Y_LSB = 0;
	localparam int FIELD_X_LSB = 10;

	// Base clock
	localparam int unsigned CLK_PERIOD_NS = 8;

	// Timing unit clock and deflection rate
	localparam int unsigned TIMING_CLK_KHZ = 1536;
	localparam int unsigned DEFLECT_KHZ = 12;
	localparam int unsigned TICKS_PER_PERIOD = TIMING_CLK_KHZ / DEFLECT_KHZ;
	localparam int PHASE_CNT_W = 7;
	localparam logic [6:0] PHASE_STEP = 7'h20;
	localparam logic [6:0] PHASE_LAST = 7'(TICKS_PER_PERIOD - 1);

	// Unblank pulse window, least rounds up, longest rounds down
	localparam int unsigned UNBLANK_MIN_NS = 83300;
	localparam int unsigned UNBLANK_MAX_NS = 90000;
	localparam int unsigned UNBLANK_MIN_CYC = (UNBLANK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned UNBLANK_MAX_CYC = UNBLANK_MAX_NS / CLK_PERIOD_NS;

	// Longest time for one conic, from the second strobe
	localparam int unsigned GEN_MAX_NS = 550000;
	localparam int unsigned GEN_MAX_CYC = GEN_MAX_NS / CLK_PERIOD_NS;
	localparam int GEN_CNT_W = 17;

	// Sender strobe timing
	localparam int unsigned STROBE_SPACING_NS = 8000;
	localparam int unsigned STROBE_SPACING_CYC =
		(STROBE_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned STROBE_WIDTH_NS = 1000;
	localparam int unsigned STROBE_WIDTH_CYC =
		(STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SEND_CNT_W = 11;

	// Diagnostics
	localparam int DIAG_INSTR_W = 6;
	localparam int DIAG_DATA_W = 13;
	localparam logic [2:0] DIAG_SEL_STATUS = 3'h0;
	localparam logic [2:0] DIAG_SEL_AX = 3'h1;
	localparam logic [2:0] DIAG_SEL_AY = 3'h2;
	localparam logic [2:0] DIAG_SEL_BX = 3'h3;
	localparam logic [2:0] DIAG_SEL_BY = 3'h4;

	// Reset values
	localparam logic [19:0] WORD_RESET = 20'h0_0000;
	localparam logic [9:0] COMP_ZERO = 10'h000;

	// Test mode pattern: largest circle
	localparam logic [19:0] TEST_MAJOR_WORD = 20'h7_FC00;
	localparam logic [19:0] TEST_MINOR_WORD = 20'h0_01FF;

	typedef enum logic [4:0] {
		GEN_ARM_MAJOR = 5'b0_0001,
		GEN_ARM_MINOR = 5'b0_0010,
		GEN_ALIGN = 5'b0_0100,
		GEN_DRAW = 5'b0_1000,
		GEN_RELEASE = 5'b1_0000
	} gen_state_type;

	typedef enum logic [4:0] {
		SND_IDLE = 5'b0_0001,
		SND_MAJOR = 5'b0_0010,
		SND_SPACE = 5'b0_0100,
		SND_MINOR = 5'b0_1000,
		SND_WAIT = 5'b1_0000
	} send_state_type;

endpackage

//--- rtl/conic_sender.sv
// Display logic end: sends one conic as two strobed words
`timescale 1ns/100ps
module conic_sender
	import conic_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Link
	conic_link_if.sender link,
	// User side
	input wire logic send_valid,
	output logic send_ready,
	input wire logic [WORD_W-1:0] major_word,
	input wire logic [WORD_W-1:0] minor_word,
	input wire logic test_mode
);

	send_state_type state_r;
	logic [SEND_CNT_W-1:0] cnt_r;
	logic [WORD_W-1:0] minor_r;
	logic [WORD_W-1:0] data_r;
	logic reset_seen_r;

	assign send_ready = state_r == SND_IDLE;
	assign link.data = data_r;
	assign link.strobe_major = state_r == SND_MAJOR;
	assign link.strobe_minor = state_r == SND_MINOR;

	////////////////////////////////////////////////////////////////////////
	// Sequence: major word, spacing, minor word, wait for the reset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= SND_IDLE;
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			unique case (state_r)
				SND_IDLE: begin
					cnt_r <= '0;
					if (send_valid) begin
						state_r <= SND_MAJOR;
					end
				end
				SND_MAJOR: begin
					if (cnt_r == SEND_CNT_W'(STROBE_WIDTH_CYC - 1)) begin
						state_r <= SND_SPACE;
					end
				end
				SND_SPACE: begin
					// Counted from the first strobe's leading edge
					if (cnt_r == SEND_CNT_W'(STROBE_SPACING_CYC - 1)) begin
						state_r <= SND_MINOR;
						cnt_r <= '0;
					end
				end
				SND_MINOR: begin
					if (cnt_r == SEND_CNT_W'(STROBE_WIDTH_CYC - 1)) begin
						state_r <= SND_WAIT;
					end
				end
				SND_WAIT: begin
					cnt_r <= '0;
					if (link.ready_reset || reset_seen_r) begin
						state_r <= SND_IDLE;
					end
				end
				default: state_r <= SND_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Words, panel patterns replace user words in test mode
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			data_r <= WORD_RESET;
			minor_r <= WORD_RESET;
		end else if (state_r == SND_IDLE && send_valid) begin
			data_r <= test_mode ? TEST_MAJOR_WORD : major_word;
			minor_r <= test_mode ? TEST_MINOR_WORD : minor_word;
		end else if (state_r == SND_SPACE && cnt_r == SEND_CNT_W'(STROBE_SPACING_CYC - 1)) begin
			data_r <= minor_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// A short draw can hand back while the minor strobe is still high
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reset_seen_r <= 1'b0;
		end else if (state_r == SND_IDLE) begin
			reset_seen_r <= 1'b0;
		end else if (link.ready_reset) begin
			reset_seen_r <= 1'b1;
		end
	end

endmodule

//--- sim/conic_link_props.sv
// Concurrent checks on the conic word link between sender and generator
`timescale 1ns/100ps
module conic_link_props
	import conic_pkg::*;
#(
	parameter int unsigned gen_max_cyc = GEN_MAX_CYC,
	parameter int unsigned unblank_cyc = UNBLANK_MIN_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Link
	input wire logic [WORD_W-1:0] data,
	input wire logic strobe_major,
	input wire logic strobe_minor,
	input wire logic ready_reset
);
	logic major_seen_r;
	logic minor_seen_r;
	logic [10:0] gap_r;
	logic [7:0] high_r;
	logic [17:0] wait_r;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	////////////////////////////////////////////////////////////////////////////////
	// Conic progress, cleared by the hand-back pulse
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			major_seen_r <= 1'b0;
		else if (ready_reset)
			major_seen_r <= 1'b0;
		else if ($rose(strobe_major))
			major_seen_r <= 1'b1;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			minor_seen_r <= 1'b0;
		else if (ready_reset)
			minor_seen_r <= 1'b0;
		else if ($rose(strobe_minor))
			minor_seen_r <= 1'b1;
	end

	// Saturates so a lone major word never wraps into a false failure
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			gap_r <= 11'h000;
		else if ($rose(strobe_major))
			gap_r <= 11'h001;
		else if (gap_r != 11'h7FF)
			gap_r <= gap_r + 11'h001;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			high_r <= 8'h00;
		else
			high_r <= (strobe_major || strobe_minor) ? high_r + 8'h01 : 8'h00;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			wait_r <= 18'h0_0000;
		else
			wait_r <= minor_seen_r ? wait_r + 18'h0_0001 : 18'h0_0000;
	end

	////////////////////////////////////////////////////////////////////////////////
	sequence minor_edge;
		$rose(strobe_minor);
	endsequence

	sequence hand_back;
		ready_reset ##1 !ready_reset;
	endsequence

	minor_after_major_a: assert property (minor_edge |-> major_seen_r && !minor_seen_r)
		else $error("minor word without a pending major word");
	strobe_spacing_a: assert property (minor_edge |-> gap_r >= 11'(STROBE_SPACING_CYC))
		else $error("strobe leading edges too close");
	hold_after_minor_a: assert property (minor_seen_r |-> !$rose(strobe_major))
		else $error("strobe sent before hand-back");
	ready_pulse_a: assert property ($rose(ready_reset) |-> hand_back)
		else $error("hand-back is not a single pulse");
	ready_cause_a: assert property (ready_reset |-> minor_seen_r && major_seen_r)
		else $error("hand-back without a complete conic");
	gen_bound_a: assert property (minor_seen_r |->
		wait_r <= 18'(gen_max_cyc + unblank_cyc + 8))
		else $error("conic generation overran");
	strobe_width_a: assert property ($fell(strobe_major) |-> high_r == 8'(STROBE_WIDTH_CYC))
		else $error("strobe width wrong");
	data_hold_a: assert property (strobe_major && $past(strobe_major) |-> $stable(data))
		else $error("data moved under a strobe");
endmodule

//--- sim/tb.sv
// Bench: sender and generator joined by the link, checked end to end
`timescale 1ns/100ps
module tb;
	import conic_pkg::*;
	localparam int unsigned UNB = 40;
	localparam int unsigned GMAX = 2000;
	localparam logic [19:0] MAJ [5] = '{20'h7_FC00, 20'h8_00C0, 20'hF_FC00, 20'h2_037F,
		20'h4_0000};
	localparam logic [19:0] MNR [5] = '{20'h0_01FF, 20'h0_0000, 20'hF_FC00, 20'hA_5C3A,
		20'h5_5555};
	logic clk;
	logic rstn = 1'b0;
	logic tclk;
	logic tclk_on = 1'b1;
	logic send_valid = 1'b0;
	logic send_ready;
	logic [WORD_W-1:0] major_word = 20'h0_0000;
	logic [WORD_W-1:0] minor_word = 20'h0_0000;
	logic test_mode = 1'b0;
	logic [DIAG_INSTR_W-1:0] diag_instr = 6'h00;
	logic [DIAG_DATA_W-1:0] diag_data;
	logic diag_sync;
	logic unblank;
	logic [1:0] video_level;
	logic [3:0] phase;
	logic [COMP_W-1:0] ax_s, ay_s, bx_s, by_s;
	logic [2:0] dk = 3'h0;
	logic [12:0] d;
	int n_fail = 0;
	int n_compared = 0;

	conic_link_if conic_link_if_i();
	conic_sender conic_sender_i(.clk(clk), .rstn(rstn), .link(conic_link_if_i),
		.send_valid(send_valid), .send_ready(send_ready), .major_word(major_word),
		.minor_word(minor_word), .test_mode(test_mode));
	conic_generator #(.unblank_cyc(UNB), .gen_max_cyc(GMAX)) conic_generator_i(.clk(clk),
		.rstn(rstn), .link(conic_link_if_i), .timing_clk(tclk), .diag_instr(diag_instr),
		.diag_data(diag_data), .diag_sync(diag_sync), .unblank(unblank),
		.video_level(video_level), .phase(phase), .ax_sample(ax_s), .ay_sample(ay_s),
		.bx_sample(bx_s), .by_sample(by_s));
	conic_link_props #(.gen_max_cyc(GMAX), .unblank_cyc(UNB)) conic_link_props_i(.clk(clk),
		.rstn(rstn), .data(conic_link_if_i.data), .strobe_major(conic_link_if_i.strobe_major),
		.strobe_minor(conic_link_if_i.strobe_minor),
		.ready_reset(conic_link_if_i.ready_reset));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Faster than the real timing clock to keep the run short; odd offset keeps its edges 1 ns ahead of the clk rising edge
	initial begin
		tclk = 1'b0;
		#3;
		forever #48 tclk = tclk_on ? ~tclk : 1'b0;
	end

	initial begin
		#480000;
		n_fail++;
		$display("[FAIL] %0t watchdog expired", $time);
		wrap_up;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("Compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic ok, input string what);
		n_compared++;
		if (!ok) begin
			n_fail++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask

	// Brightness band: top two magnitude bits of the larger major component
	function automatic logic [1:0] lvl_of(input logic [19:0] w);
		logic [9:0] a;
		logic [9:0] b;
		a = w[19] ? ~w[19:10] : w[19:10];
		b = w[9] ? ~w[9:0] : w[9:0];
		return (a[8:7] > b[8:7]) ? a[8:7] : b[8:7];
	endfunction

	// Instruction must change to be taken, so the upper bits rotate through nonzero values
	task automatic diag(input logic [2:0] sel, output logic [12:0] q);
		int i;
		dk = (dk == 3'h7) ? 3'h1 : dk + 3'h1;
		@(posedge clk);
		diag_instr <= {dk, sel};
		for (i = 0; i < 20 && diag_sync !== 1'b1; i++)
			@(posedge clk);
		check(i < 20, "no diag answer");
		q = diag_data;
	endtask

	task automatic send(input logic [19:0] maj, input logic [19:0] mnr, input logic tm,
			input logic wd);
		int i;
		int hi;
		logic [19:0] em;
		logic [19:0] en;
		em = tm ? TEST_MAJOR_WORD : maj;
		en = tm ? TEST_MINOR_WORD : mnr;
		hi = 0;
		@(posedge clk);
		major_word <= maj;
		minor_word <= mnr;
		test_mode <= tm;
		send_valid <= 1'b1;
		@(posedge clk);
		for (i = 0; i < 200 && send_ready !== 1'b1; i++)
			@(posedge clk);
		check(i < 200, "sender not ready");
		send_valid <= 1'b0;
		for (i = 0; i < 6000 && conic_link_if_i.ready_reset !== 1'b1; i++) begin
			@(posedge clk);
			if (unblank === 1'b1) begin
				hi++;
				check(video_level === lvl_of(em), "video level");
				check(ax_s === (phase[0] ? em[19:10] : ~em[19:10]), "ax sample");
				check(ay_s === (phase[0] ? em[9:0] : ~em[9:0]), "ay sample");
				check(bx_s === (phase[1] ? en[19:10] : ~en[19:10]), "bx sample");
				check(by_s === (phase[1] ? en[9:0] : ~en[9:0]), "by sample");
				check(phase[2] === ~phase[0] && phase[3] === ~phase[1], "phase set");
			end
		end
		check(i < 6000, "no hand-back");
		if (wd)
			check(i <= 1010 + GMAX + UNB, "draw overran");
		else
			check(hi == UNB, "unblank width");
		diag(3'h1, d);
		check(d === {3'h0, em[19:10]}, "ax field");
		diag(3'h2, d);
		check(d === {3'h0, em[9:0]}, "ay field");
		diag(3'h3, d);
		check(d === {3'h0, en[19:10]}, "bx field");
		diag(3'h4, d);
		check(d === {3'h0, en[9:0]}, "by field");
		diag(3'h0, d);
		check(d[12:8] === GEN_ARM_MAJOR, "not rearmed");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		for (int k = 0; k < 5; k++) begin
			send(MAJ[k], MNR[k], 1'b0, 1'b0);
		end
		$display("Test conic table done");
		send(20'h1_2345, 20'h6_789A, 1'b1, 1'b0);
		$display("Test test mode done");
		tclk_on <= 1'b0;
		send(20'h3_0C0C, 20'h0_0303, 1'b0, 1'b1);
		tclk_on <= 1'b1;
		$display("Test stopped timing done");
		for (int s = 5; s < 8; s++) begin
			diag(3'(s), d);
			check(d === 13'h0000, "unused select");
		end
		$display("Test diag done");
		wrap_up;
	end
endmodule
